// *** testbench/ipk_dev_model.sv ***
`timescale 1ns/1ps

module ipk_dev_model #(
   parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary address
   parameter int STRETCH = 12
) (
   input logic clk,
   input logic rst,
   input logic scl,
   input logic sda,
   input logic slow,
   input logic conv_stb,
   input logic [7:0] conv_val,
   input logic [2:0] interval,
   output logic scl_oe,
   output logic sda_oe
);
   logic scl_q, sda_q, act, tx, rd, ign, hi_sel, mack, pk_wr;
   logic start_c, stop_c, rise, fall;
   logic [3:0] bitn;
   logic [1:0] byten;
   logic [7:0] sh, ptr, peak, hi_b, nxt_b;
   logic [5:0] st_cnt;
   logic [15:0] word;

   // bus conditions seen on the wired lines
   assign start_c = scl & scl_q & sda_q & !sda;
   assign stop_c = scl & scl_q & !sda_q & sda;
   assign rise = scl & !scl_q;
   assign fall = !scl & scl_q;
   assign word = (ptr == 8'h07) ? {4'h0, peak, 4'h0} : 16'h0000;
   assign nxt_b = hi_sel ? word[7:0] : word[15:8];

   // target side of the serial port
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {scl_q, sda_q} <= 2'b11;
         {act, tx, rd, ign, hi_sel, mack, pk_wr} <= 7'h00;
         bitn <= 4'h0;
         byten <= 2'h0;
         {sh, ptr, hi_b} <= 24'h000000;
         sda_oe <= 1'b0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         pk_wr <= 1'b0;
         if (start_c) begin
            {act, tx, rd, ign, hi_sel} <= 5'b10000;
            bitn <= 4'hF; // the clock fall that closes the start is no bit
            byten <= 2'h0;
            sda_oe <= 1'b0;
         end else if (stop_c) begin
            act <= 1'b0;
            tx <= 1'b0;
            sda_oe <= 1'b0;
         end else if (act && !ign && rise) begin
            if (bitn == 4'h8 && tx)
               mack <= !sda;
            else if (bitn < 4'h8 && !tx)
               sh <= {sh[6:0], sda};
         end else if (act && !ign && fall) begin
            if (bitn == 4'hF) begin
               bitn <= 4'h0;
            end else if (bitn < 4'h7) begin
               bitn <= bitn + 4'h1;
               if (tx) begin
                  sh <= {sh[6:0], 1'b0};
                  sda_oe <= !sh[6];
               end
            end else if (bitn == 4'h7) begin
               bitn <= 4'h8;
               sda_oe <= 1'b0;
               if (!tx) begin
                  byten <= (byten == 2'h3) ? 2'h2 : byten + 2'h1;
                  // master code is never acknowledged
                  if (byten == 2'h0 && sh[7:3] == 5'b00001) begin
                     ign <= 1'b1;
                  end else if (byten == 2'h0 && sh[7:1] != DEV_ADDR) begin
                     ign <= 1'b1;
                  end else begin
                     sda_oe <= 1'b1;
                     if (byten == 2'h0)
                        rd <= sh[0];
                     if (byten == 2'h1)
                        ptr <= sh;
                     if (byten == 2'h2)
                        hi_b <= sh;
                     if (byten == 2'h3)
                        pk_wr <= (ptr == 8'h07);
                  end
               end
            end else begin
               bitn <= 4'h0;
               // keep sending while the master acknowledges
               if (rd && (!tx || mack)) begin
                  tx <= 1'b1;
                  sh <= nxt_b;
                  sda_oe <= !nxt_b[7];
                  hi_sel <= !hi_sel;
               end else begin
                  sda_oe <= 1'b0;
                  ign <= rd;
               end
            end
         end
      end
   end

   // clock stretching when asked to answer slowly
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         st_cnt <= 6'h00;
      else if (slow && fall)
         st_cnt <= 6'(STRETCH);
      else if (st_cnt != 6'h00)
         st_cnt <= st_cnt - 6'h01;
   end
   assign scl_oe = (st_cnt != 6'h00);

   // peak tracking, bus write wins over a conversion
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         peak <= 8'h00;
      else if (pk_wr)
         peak <= {hi_b[3:0], sh[7:4]};
      else if (conv_stb && interval != 3'h0 && conv_val > peak)
         peak <= conv_val;
   end
endmodule

// *** testbench/ipk_master_tb.sv ***
`timescale 1ns/1ps
`include "ipk_regs.svh"

module ipk_master_tb;
   logic clk, rst, read, write, slow, conv_stb, waitrequest;
   logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, scl, sda;
   logic [4:0] address;
   logic [31:0] writedata, readdata, rv;
   logic [7:0] conv_val;
   logic [2:0] interval;
   logic sgl = 1'b0;
   logic [7:0] cv [4] = '{8'h40, 8'h30, 8'h7F, 8'h10};
   int err_count = 0;
   int num_checks = 0;

   // open-drain lines with pull-ups
   assign scl = !(scl_oe | m_scl_oe);
   assign sda = !(sda_oe | m_sda_oe);

   ipk_master #(.QTR_FAST(4), .QTR_HS(3)) dut (.clk(clk), .rst(rst),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .scl_in(scl), .scl_o(), .scl_oe(scl_oe),
      .sda_in(sda), .sda_o(), .sda_oe(sda_oe));

   ipk_dev_model #(.DEV_ADDR(7'h2A)) dev (.clk(clk), .rst(rst), .scl(scl),
      .sda(sda), .slow(slow), .conv_stb(conv_stb), .conv_val(conv_val),
      .interval(interval), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic give_verdict;
      if (err_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one avalon access, held until waitrequest is seen low
   task automatic av(input logic wr, input logic [4:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (waitrequest !== 1'b0) begin
         err_count++;
         give_verdict;
      end
      // answer taken at the edge that sees waitrequest low
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask

   // start a transfer at pointer 07h and wait for it to finish
   task automatic xfer(input logic [1:0] op, input logic [6:0] tgt,
         input logic [31:0] st_exp);
      int n;
      n = 0;
      av(1'b1, `IPK_OFS_TARGET, {16'h0, 8'h07, 1'b0, tgt}, rv);
      av(1'b1, `IPK_OFS_CTRL, {28'h0, sgl, op, 1'b1}, rv);
      do begin
         av(1'b0, `IPK_OFS_STATUS, 32'h0, rv);
         n++;
      end while (rv[0] !== 1'b0 && n < 3000);
      if (n >= 3000) begin
         err_count++;
         give_verdict;
      end
      check("status", rv, st_exp);
   endtask

   task automatic rchk(input logic [31:0] exp);
      av(1'b0, `IPK_OFS_RDATA, 32'h0, rv);
      check("rdata", rv, exp);
   endtask

   task automatic conv(input logic [2:0] iv, input logic [7:0] v);
      @(posedge clk);
      interval <= iv;
      conv_val <= v;
      conv_stb <= 1'b1;
      @(posedge clk);
      conv_stb <= 1'b0;
   endtask

   initial begin
      {rst, read, write, slow, conv_stb} = 5'b10000;
      address = 5'h00;
      writedata = 32'h0;
      conv_val = 8'h00;
      interval = 3'h0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      av(1'b0, 5'h18, 32'h0, rv);
      check("unmapped", rv, 32'h0);
      xfer(2'd1, 7'h2A, 32'h8);
      rchk(32'h0);
      // on-demand conversions leave the peak alone
      conv(3'h0, 8'h55);
      xfer(2'd2, 7'h2A, 32'h8);
      rchk(32'h0);
      foreach (cv[i])
         conv(3'h2, cv[i]);
      xfer(2'd2, 7'h2A, 32'h8);
      rchk(32'h07F0);
      // reserved bits must go out as zero
      av(1'b1, `IPK_OFS_WDATA, 32'hFFFF, rv);
      xfer(2'd0, 7'h2A, 32'h8);
      xfer(2'd2, 7'h2A, 32'h8);
      rchk(32'h0FF0);
      xfer(2'd3, 7'h2A, 32'h8);
      xfer(2'd2, 7'h2A, 32'h8);
      rchk(32'h0);
      // single-byte write stops after the upper byte: peak untouched
      sgl = 1'b1;
      xfer(2'd0, 7'h2A, 32'h8);
      sgl = 1'b0;
      xfer(2'd2, 7'h2A, 32'h8);
      rchk(32'h0);
      conv(3'h2, 8'h01);
      // three words with a slow, stretching target
      av(1'b1, `IPK_OFS_CFG, 32'h2, rv);
      slow <= 1'b1;
      xfer(2'd2, 7'h2A, 32'h8);
      rchk(32'h0010);
      slow <= 1'b0;
      xfer(2'd2, 7'h2B, 32'hA);
      // every master code low pattern, then high rate
      for (int m = 0; m < 8; m++) begin
         av(1'b1, `IPK_OFS_CFG, 32'h1000 | (32'(m) << 8), rv);
         xfer(2'd1, 7'h2A, 32'h8);
         rchk(32'h0010);
      end
      give_verdict;
   end
endmodule

// *** verilog/ipk_master.sv ***
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ipk_regs.svh"

module ipk_master
   import ipk_pkg::*;
#(
   parameter int QTR_FAST = `IPK_QTR_FAST,
   parameter int QTR_HS = `IPK_QTR_HS
) (
   input logic clk,
   input logic rst,
   input logic [4:0] address,
   input logic read,
   input logic write,
   input logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input logic scl_in,
   output logic scl_o,
   output logic scl_oe,
   input logic sda_in,
   output logic sda_o,
   output logic sda_oe
);

   ipk_state_t st;
   ipk_step_t step;
   ipk_op_t op, go_op;
   ipk_status_t stat;
   logic [1:0] q;
   logic [2:0] mcode;
   logic [3:0] bitn;
   logic [6:0] taddr;
   logic [7:0] rx, words_left, ptr, words, tx_byte;
   logic [15:0] wdata, rword, wword;
   logic [31:0] rd_mux;
   logic hs_active, tick, scl_s, sda_s, ack_n, single, hs_en;
   logic wr_ok, go, rx_step, last_byte, drive_low, byte_end;

   ipk_sync #(.WIDTH(2)) u_sync (.clk(clk), .rst(rst),
      .din({scl_in, sda_in}), .dout({scl_s, sda_s}));

   ipk_tick #(.QTR_SLOW(QTR_FAST), .QTR_FAST(QTR_HS)) u_tick (.clk(clk),
      .rst(rst), .fast(hs_active), .tick(tick));

   // bus strobes; a write takes effect in the cycle waitrequest is low
   assign wr_ok = write && !waitrequest;
   assign go_op = ipk_op_t'(writedata[`IPK_CTRL_OP_LSB +: 2]);
   assign go = wr_ok && address == `IPK_OFS_CTRL &&
      writedata[`IPK_CTRL_GO] && st == ST_IDLE;
   assign byte_end = tick && st == ST_BIT && q == 2'h3 && bitn == 4'h8;
   assign rx_step = step == SQ_RHI || step == SQ_RLO;
   assign last_byte = (step == SQ_RHI) ? single : words_left == 8'h00;

   // outgoing word: peak clear forces zero, peak writes keep reserved zero
   assign wword = (op == OP_CLR_PEAK) ? `IPK_PEAK_RESET :
      (ptr == `IPK_PTR_PEAK) ? (wdata & `IPK_PEAK_FIELD_MASK) :
      wdata;

   // byte to shift out for each step
   always_comb begin
      case (step)
         SQ_MCODE: tx_byte = {`IPK_MCODE_TOP, mcode};
         SQ_ADDRW: tx_byte = {taddr, 1'h0};
         SQ_ADDRR: tx_byte = {taddr, 1'h1};
         SQ_PTR: tx_byte = (op == OP_CLR_PEAK) ? `IPK_PTR_PEAK : ptr;
         SQ_HI: tx_byte = wword[15:8];
         SQ_LO: tx_byte = wword[7:0];
         default: tx_byte = 8'hFF;
      endcase
   end

   // level wanted on data for the current bit slot; ack slot released when sending, driven low on read bytes except the last
   assign drive_low = rx_step ? (bitn == 4'h8 && !last_byte) :
      (bitn != 4'h8 && !tx_byte[3'(4'h7 - bitn)]);

   // bit engine and byte sequencer; scl waits in quarter 1 while stretched
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= ST_IDLE;
         step <= SQ_ADDRW;
         q <= 2'h0;
         bitn <= 4'h0;
         hs_active <= 1'h0;
         words_left <= 8'h00;
         scl_oe <= 1'h0;
         sda_oe <= 1'h0;
      end else if (go) begin
         st <= ST_START;
         q <= 2'h0;
         words_left <= words;
         step <= hs_en ? SQ_MCODE :
            (go_op == OP_READ_CUR) ? SQ_ADDRR : SQ_ADDRW;
      end else if (tick && st != ST_IDLE) begin
         if (!(q == 2'h1 && !scl_s))
            q <= q + 2'h1;
         case (st)
            ST_START: begin
               // data low while clock high, then clock low
               case (q)
                  2'h0: sda_oe <= 1'h0;
                  2'h1: scl_oe <= 1'h0;
                  2'h2: sda_oe <= 1'h1;
                  default: begin
                     scl_oe <= 1'h1;
                     st <= ST_BIT;
                     bitn <= 4'h0;
                  end
               endcase
            end
            ST_BIT: begin
               case (q)
                  2'h0: sda_oe <= drive_low;
                  2'h1: scl_oe <= 1'h0;
                  2'h2: ;
                  default: begin
                     scl_oe <= 1'h1;
                     bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
                  end
               endcase
               if (q == 2'h3 && bitn == 4'h8) begin
                  case (step)
                     SQ_MCODE: begin
                        hs_active <= 1'h1;
                        st <= ST_START;
                        step <= (op == OP_READ_CUR) ? SQ_ADDRR : SQ_ADDRW;
                     end
                     SQ_ADDRW: begin
                        if (ack_n)
                           st <= ST_STOP;
                        else
                           step <= SQ_PTR;
                     end
                     SQ_PTR: begin
                        if (ack_n) begin
                           st <= ST_STOP;
                        end else if (op == OP_READ_PTR) begin
                           step <= SQ_ADDRR;
                           st <= ST_START;
                        end else begin
                           step <= SQ_HI;
                        end
                     end
                     SQ_HI: begin
                        if (ack_n || single)
                           st <= ST_STOP;
                        else
                           step <= SQ_LO;
                     end
                     SQ_ADDRR: begin
                        if (ack_n)
                           st <= ST_STOP;
                        else
                           step <= SQ_RHI;
                     end
                     SQ_RHI: begin
                        if (single)
                           st <= ST_STOP;
                        else
                           step <= SQ_RLO;
                     end
                     SQ_RLO: begin
                        if (words_left == 8'h00) begin
                           st <= ST_STOP;
                        end else begin
                           step <= SQ_RHI;
                           words_left <= words_left - 8'h01;
                        end
                     end
                     default: st <= ST_STOP;
                  endcase
               end
            end
            ST_STOP: begin
               // data rises while clock high; high rate ends here
               case (q)
                  2'h0: sda_oe <= 1'h1;
                  2'h1: scl_oe <= 1'h0;
                  2'h2: sda_oe <= 1'h0;
                  default: begin
                     st <= ST_IDLE;
                     hs_active <= 1'h0;
                  end
               endcase
            end
            default: st <= ST_IDLE;
         endcase
      end
   end

   // open drain: the driven level is always low, oe decides
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_o <= 1'h0;
         sda_o <= 1'h0;
      end else begin
         scl_o <= 1'h0;
         sda_o <= 1'h0;
      end
   end

   // sample data in quarter 2, once clock is seen high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx <= 8'h00;
         ack_n <= 1'h1;
         rword <= 16'h0000;
      end else begin
         if (tick && st == ST_BIT && q == 2'h2) begin
            if (bitn == 4'h8)
               ack_n <= sda_s;
            else
               rx <= {rx[6:0], sda_s};
         end
         if (byte_end && step == SQ_RHI)
            rword[15:8] <= rx;
         if (byte_end && step == SQ_RLO)
            rword[7:0] <= rx;
      end
   end

   // setup registers; ignored while a transfer runs so it stays coherent
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         op <= OP_WRITE;
         single <= 1'h0;
         taddr <= 7'h00;
         ptr <= 8'h00;
         wdata <= 16'h0000;
         words <= 8'h00;
         mcode <= 3'h0;
         hs_en <= 1'h0;
      end else if (wr_ok && st == ST_IDLE) begin
         case (address)
            `IPK_OFS_CTRL: begin
               op <= go_op;
               single <= writedata[`IPK_CTRL_SINGLE];
            end
            `IPK_OFS_TARGET: begin
               taddr <= writedata[6:0];
               ptr <= writedata[15:8];
            end
            `IPK_OFS_WDATA: wdata <= writedata[15:0];
            `IPK_OFS_CFG: begin
               words <= writedata[`IPK_CFG_WORDS_LSB +: 8];
               mcode <= writedata[`IPK_CFG_MCODE_LSB +: 3];
               hs_en <= writedata[`IPK_CFG_HS];
            end
            default: ;
         endcase
      end
   end

   // sticky flags: a new start clears them, events set them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat <= '0;
      end else begin
         if (go)
            stat <= '0;
         if (byte_end && ack_n && (step == SQ_ADDRW || step == SQ_ADDRR))
            stat.anack <= 1'h1;
         if (byte_end && ack_n &&
            (step == SQ_PTR || step == SQ_HI || step == SQ_LO))
            stat.dnack <= 1'h1;
         if (byte_end && !ack_n && step == SQ_MCODE)
            stat.mack <= 1'h1;
         if (tick && st == ST_STOP && q == 2'h3)
            stat.done <= 1'h1;
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      case (address)
         `IPK_OFS_CTRL: rd_mux = {28'h0000000, single, op, 1'h0};
         `IPK_OFS_TARGET: rd_mux = {16'h0000, ptr, 1'h0, taddr};
         `IPK_OFS_WDATA: rd_mux = {16'h0000, wdata};
         `IPK_OFS_RDATA: rd_mux = {16'h0000, rword};
         `IPK_OFS_STATUS: rd_mux = {26'h0000000, hs_active, stat,
            st != ST_IDLE};
         `IPK_OFS_CFG: rd_mux = {19'h00000, hs_en, 1'h0, mcode, words};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // fixed one wait cycle per access: waitrequest drops for one cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         waitrequest <= 1'h1;
         readdata <= 32'h00000000;
      end else if ((read || write) && waitrequest) begin
         waitrequest <= 1'h0;
         readdata <= rd_mux;
      end else begin
         waitrequest <= 1'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_open_drain: assert property (!sda_o && !scl_o)
      else $error("open-drain pin driven high");
   chk_start_only: assert property (
      ($rose(sda_oe) && !scl_oe) |-> $past(st) == ST_START)
      else $error("data fell with clock high outside a start");
   chk_stop_only: assert property (
      ($fell(sda_oe) && !scl_oe) |-> $past(st) == ST_STOP ##1 st == ST_STOP)
      else $error("data rose with clock high outside a stop");
   chk_hs_end_stop: assert property (
      $fell(hs_active) |-> $past(st) == ST_STOP && st == ST_IDLE)
      else $error("high rate left without stop");
   chk_hs_after_mcode: assert property (
      $rose(hs_active) |-> $past(step) == SQ_MCODE && st == ST_START)
      else $error("high rate entered without master code");
   chk_mcode_shape: assert property (
      (st == ST_BIT && step == SQ_MCODE && q == 2'h1 && bitn < 4'h5)
      |-> sda_oe == (bitn != 4'h4))
      else $error("master code prefix not 00001");
   chk_peak_reserved: assert property (
      (st == ST_BIT && ptr == `IPK_PTR_PEAK && q == 2'h1 &&
      ((step == SQ_HI && bitn < 4'h4) || (step == SQ_LO && bitn > 4'h3 &&
      bitn < 4'h8))) |-> sda_oe)
      else $error("reserved peak bit sent as one");
   chk_last_nack: assert property (
      (st == ST_BIT && step == SQ_RLO && bitn == 4'h8 && q == 2'h1 &&
      words_left == 8'h00) |-> !sda_oe)
      else $error("last read byte acknowledged");
   chk_ptr_first: assert property (
      (byte_end && step == SQ_ADDRW && !ack_n) |=> step == SQ_PTR)
      else $error("pointer byte not first after address");
   chk_bus_answer: assert property (
      ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle");
   cov_write_done: cover property (
      byte_end && step == SQ_LO ##[1:1000] st == ST_IDLE);
   cov_read_words: cover property (byte_end && step == SQ_RLO && !last_byte);
   cov_hs_transfer: cover property ($rose(hs_active));
   cov_addr_nack: cover property ($rose(stat.anack));

endmodule

// *** verilog/ipk_pkg.sv ***
package ipk_pkg;

   // transfer kinds started through the control register
   typedef enum logic [1:0] {
      OP_WRITE,
      OP_READ_PTR,
      OP_READ_CUR,
      OP_CLR_PEAK
   } ipk_op_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_START,
      ST_BIT,
      ST_STOP
   } ipk_state_t;

   typedef enum logic [3:0] {
      SQ_MCODE,
      SQ_ADDRW,
      SQ_PTR,
      SQ_HI,
      SQ_LO,
      SQ_ADDRR,
      SQ_RHI,
      SQ_RLO
   } ipk_step_t;

   // sticky outcome flags of the last transfer
   typedef struct packed {
      logic mack;
      logic done;
      logic dnack;
      logic anack;
   } ipk_status_t;

endpackage

// *** verilog/ipk_regs.svh ***
`ifndef IPK_REGS_SVH
`define IPK_REGS_SVH

// byte offsets of the controller's own registers
`define IPK_OFS_CTRL 5'h00
`define IPK_OFS_TARGET 5'h04
`define IPK_OFS_WDATA 5'h08
`define IPK_OFS_RDATA 5'h0C
`define IPK_OFS_STATUS 5'h10
`define IPK_OFS_CFG 5'h14

// control fields
`define IPK_CTRL_GO 0
`define IPK_CTRL_OP_LSB 1
`define IPK_CTRL_SINGLE 3

// config fields
`define IPK_CFG_WORDS_LSB 0
`define IPK_CFG_MCODE_LSB 8
`define IPK_CFG_HS 12

// target register map of the converter
`define IPK_PTR_PEAK 8'h07
`define IPK_PEAK_RESET 16'h0000
`define IPK_PEAK_FIELD_MASK 16'h0FF0
`define IPK_MCODE_TOP 5'h01

// timing: bus rates in kHz, quarter periods in clk cycles (rounded up)
`define IPK_CLK_KHZ 100000
`define IPK_FAST_KHZ 400
`define IPK_HS_KHZ 3400
`define IPK_QTR_FAST \
   ((`IPK_CLK_KHZ + 4 * `IPK_FAST_KHZ - 1) / (4 * `IPK_FAST_KHZ))
`define IPK_QTR_HS \
   ((`IPK_CLK_KHZ + 4 * `IPK_HS_KHZ - 1) / (4 * `IPK_HS_KHZ))

`endif

// *** verilog/ipk_sync.sv ***
`timescale 1ns/1ps

module ipk_sync #(
   parameter int WIDTH = 2
) (
   input logic clk,
   input logic rst,
   input logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   if (WIDTH < 1) begin : g_bad
      $error("ipk_sync: WIDTH must be at least 1");
   end

   // two flops per pin; the first is read by the second only
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            meta <= 1'h1;
            dout[i] <= 1'h1;
         end else begin
            meta <= din[i];
            dout[i] <= meta;
         end
      end
   end

endmodule

// *** verilog/ipk_tick.sv ***
`timescale 1ns/1ps

module ipk_tick #(
   parameter int QTR_SLOW = 63,
   parameter int QTR_FAST = 8
) (
   input logic clk,
   input logic rst,
   input logic fast,
   output logic tick
);

   if (QTR_SLOW < 1 || QTR_FAST < 1 || QTR_SLOW > 4096 || QTR_FAST > 4096)
   begin : g_bad
      $error("ipk_tick: quarter counts must lie in 1..4096");
   end

   logic [12:0] cnt;

   // one pulse per quarter bus period; rate switches at the next reload
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 13'h0000;
         tick <= 1'h0;
      end else if (cnt == 13'h0000) begin
         cnt <= fast ? 13'(QTR_FAST - 1) : 13'(QTR_SLOW - 1);
         tick <= 1'h1;
      end else begin
         cnt <= cnt - 13'h0001;
         tick <= 1'h0;
      end
   end

endmodule
